// File: verilog/adtrim_pkg.sv
/*
  Package for the analog die trim register bank.
  Holds the register map, field positions and reset values.
  Assumes every user writes package::name without an import.
*/
package adtrim_pkg;

  // Printed offsets are not multiples of four, so they are kept as indices
  localparam logic [7:0]  REG_IDX_SLOPE_WDOG  = 8'hf0;
  localparam logic [7:0]  REG_IDX_BANDGAP     = 8'hf1;
  localparam logic [7:0]  REG_IDX_SLEEP_REF   = 8'hf2;
  localparam logic [7:0]  REG_IDX_ADC_OFFSET  = 8'hf3;

  // Base of the window in the global map; only indices are decoded locally
  localparam logic [15:0] BASE_BLOCKING     = 16'h0200;
  localparam logic [15:0] BASE_NONBLOCKING  = 16'h0300;
  localparam int          ADDR_W            = 12;

  localparam logic [7:0]  RESET_SLOPE_WDOG  = 8'h00;
  localparam logic [7:0]  RESET_BANDGAP     = 8'h00;
  localparam logic [7:0]  RESET_SLEEP_REF   = 8'h00;
  localparam logic [7:0]  RESET_ADC_OFFSET  = 8'h00;

  // Field positions of the first register
  localparam int BIT_LINK_EN   = 7;
  localparam int BIT_LINK_ADJ  = 6;
  localparam int BIT_WDOG_EN   = 5;
  localparam int BIT_SPARE_A4  = 4;
  localparam int BIT_SPARE_A3  = 3;
  // Field positions of the second register
  localparam int BIT_BG_EN     = 7;
  localparam int BIT_BG_UP     = 5;
  localparam int BIT_BG_DOWN   = 4;
  localparam int BIT_IREF_EN   = 3;
  // Field positions of the third register
  localparam int BIT_SLP_EN    = 4;
  localparam int BIT_SLP_LOCK  = 3;
  localparam logic [7:0] SLEEP_WRITE_MASK = 8'h1f;
  // Field positions of the fourth register
  localparam int BIT_ADC_EN    = 7;
  localparam int BIT_ADC_LO    = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Neutral code: the current reference trim 000/111 means no change
  localparam logic [2:0] CODE_NEUTRAL      = 3'h0;
  // Default code of the sleep reference trim (-12.2 %)
  localparam logic [2:0] SLEEP_CODE_DFLT   = 3'h0;

  typedef struct packed {
    logic       link_slope_adjust;
    logic       wdog_trim_active;
    logic [2:0] wdog_clock_trim_code;
    logic       bandgap_slope_up;
    logic       bandgap_slope_down;
    logic [2:0] current_ref_trim_code;
    logic [2:0] sleep_ref_trim_code;
    logic       sleep_ref_locked;
    logic [2:0] adc_offset_trim_code;
  } adtrim_apply_type;

endpackage

// File: verilog/adtrim_bank.sv
/*
  Analog die trim register bank with an AXI4-Lite slave port.
  Assumes one clock, an AXI4-Lite master with one write and one read at a
  time, and analog consumers that read the effective trim outputs.
*/
//
// Contract
// - Trim values survive low power mode; reset restores every default.
// - Offsets decode relative to base 0x0200 blocking or 0x300 non-blocking.
// - Link slope adjust applies only while the link trim enable is set.
// - Watchdog clock trim code has no effect while its enable is clear.
// - Watchdog code 000-011 gives 0..+15%, 100-111 gives -20..-5%.
// - Bandgap slope bits take effect only while the bandgap enable is set.
// - Slope up increases, slope down decreases the bandgap slope.
// - Current reference trim code applies only while its enable is set.
// - Current reference codes 000 and 111 are neutral; others scale it.
// - Sleep enable clear gives the default code and no lock output; a stored lock bit still blocks writes.
// - One write of code, enable and lock applies and locks the sleep trim.
// - Once locked, further changes to the sleep trim fields are ignored.
// - Sleep codes 000 and 111 give the -12.2% default; others step it.
// - Fourth register offset trim applies only while its enable is set.
`timescale 1ns/100ps

module adtrim_bank (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET_N,
  input  wire logic                        CLK_EN,
  input  wire logic                        LOW_POWER,
  input  wire logic [adtrim_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [adtrim_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  output adtrim_pkg::adtrim_apply_type     TRIM_APPLY,
  output logic                             LINK_SLOPE_ADJUSTED,
  output logic signed [7:0]                WDOG_TRIM_PERCENT,
  output logic                             SLEEP_REF_LOCKED
);

  // Register file
  logic [7:0] slope_wdog_trim;
  logic [7:0] bandgap_iref_trim;
  logic [7:0] sleep_ref_trim;
  logic [7:0] adc_offset_trim;
  logic [7:0] next_slope_wdog_trim;
  logic [7:0] next_bandgap_iref_trim;
  logic [7:0] next_sleep_ref_trim;
  logic [7:0] next_adc_offset_trim;

  // Bus slave state
  logic [adtrim_pkg::ADDR_W-1:0] aw_addr;
  logic                          aw_held;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;
  logic                          w_held;
  logic [1:0]                    b_resp;
  logic                          b_pend;
  logic [31:0]                   r_data;
  logic [1:0]                    r_resp;
  logic                          r_pend;
  logic [adtrim_pkg::ADDR_W-1:0] next_aw_addr;
  logic                          next_aw_held;
  logic [31:0]                   next_w_data;
  logic [3:0]                    next_w_strb;
  logic                          next_w_held;
  logic [1:0]                    next_b_resp;
  logic                          next_b_pend;
  logic [31:0]                   next_r_data;
  logic [1:0]                    next_r_resp;
  logic                          next_r_pend;

  // Effective trims
  adtrim_pkg::adtrim_apply_type next_apply;
  logic signed [7:0]            next_wdog_pct;

  logic       do_write;
  logic       do_read;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] wr_byte;
  logic       wr_lane;
  logic [7:0] rd_byte;

  function automatic logic [9:0] word_index(input logic [adtrim_pkg::ADDR_W-1:0] a);
    word_index = a[adtrim_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == {2'h0, adtrim_pkg::REG_IDX_SLOPE_WDOG}) ||
                 (idx == {2'h0, adtrim_pkg::REG_IDX_BANDGAP}) ||
                 (idx == {2'h0, adtrim_pkg::REG_IDX_SLEEP_REF}) ||
                 (idx == {2'h0, adtrim_pkg::REG_IDX_ADC_OFFSET});
  endfunction

  // Handshakes: hold each channel until the response is gone
  // No ready while frozen, or a handshake would be lost
  assign S_AXI_AWREADY = !aw_held && !b_pend && CLK_EN;
  assign S_AXI_WREADY  = !w_held && !b_pend && CLK_EN;
  assign S_AXI_ARREADY = !r_pend && CLK_EN;
  assign S_AXI_BVALID  = b_pend;
  assign S_AXI_BRESP   = b_resp;
  assign S_AXI_RVALID  = r_pend;
  assign S_AXI_RDATA   = r_data;
  assign S_AXI_RRESP   = r_resp;

  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_held  = w_held;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_addr = S_AXI_AWADDR;
      next_aw_held = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
      next_w_held = 1'b1;
    end
    do_write = aw_held && w_held;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    // Byte address is four times the printed offset index
    wr_idx  = word_index(aw_addr);
    wr_hit  = idx_mapped(wr_idx);
    wr_byte = w_data[7:0];
    wr_lane = w_strb[0];
    next_b_pend = b_pend;
    next_b_resp = b_resp;
    if (do_write) begin
      next_b_pend = 1'b1;
      next_b_resp = wr_hit ? adtrim_pkg::RESP_OKAY : adtrim_pkg::RESP_SLVERR;
    end else if (b_pend && S_AXI_BREADY) begin
      next_b_pend = 1'b0;
    end
  end

  // Low power entry does not touch the registers; only reset does
  always_comb begin
    next_slope_wdog_trim   = slope_wdog_trim;
    next_bandgap_iref_trim = bandgap_iref_trim;
    next_sleep_ref_trim    = sleep_ref_trim;
    next_adc_offset_trim   = adc_offset_trim;
    if (do_write && wr_lane) begin
      if (wr_idx == {2'h0, adtrim_pkg::REG_IDX_SLOPE_WDOG}) begin
        next_slope_wdog_trim = wr_byte;
      end
      if (wr_idx == {2'h0, adtrim_pkg::REG_IDX_BANDGAP}) begin
        next_bandgap_iref_trim = wr_byte;
      end
      if (wr_idx == {2'h0, adtrim_pkg::REG_IDX_SLEEP_REF} &&
          !sleep_ref_trim[adtrim_pkg::BIT_SLP_LOCK]) begin
        // Upper bits are not stored at all
        next_sleep_ref_trim = wr_byte & adtrim_pkg::SLEEP_WRITE_MASK;
      end
      if (wr_idx == {2'h0, adtrim_pkg::REG_IDX_ADC_OFFSET}) begin
        next_adc_offset_trim = wr_byte;
      end
    end
  end

  // Read path
  always_comb begin
    do_read = S_AXI_ARVALID && S_AXI_ARREADY;
    rd_idx  = word_index(S_AXI_ARADDR);
    rd_hit  = idx_mapped(rd_idx);
    rd_byte = 8'h00;
    if (rd_idx == {2'h0, adtrim_pkg::REG_IDX_SLOPE_WDOG}) begin
      rd_byte = slope_wdog_trim;
    end else if (rd_idx == {2'h0, adtrim_pkg::REG_IDX_BANDGAP}) begin
      rd_byte = bandgap_iref_trim;
    end else if (rd_idx == {2'h0, adtrim_pkg::REG_IDX_SLEEP_REF}) begin
      rd_byte = sleep_ref_trim & adtrim_pkg::SLEEP_WRITE_MASK;
    end else if (rd_idx == {2'h0, adtrim_pkg::REG_IDX_ADC_OFFSET}) begin
      rd_byte = adc_offset_trim;
    end
    next_r_pend = r_pend;
    next_r_data = r_data;
    next_r_resp = r_resp;
    if (do_read) begin
      next_r_pend = 1'b1;
      next_r_data = {24'h000000, rd_byte};
      next_r_resp = rd_hit ? adtrim_pkg::RESP_OKAY : adtrim_pkg::RESP_SLVERR;
    end else if (r_pend && S_AXI_RREADY) begin
      next_r_pend = 1'b0;
    end
  end

  // Effective trims seen by the analog side
  always_comb begin
    next_apply = '0;
    next_apply.link_slope_adjust = slope_wdog_trim[adtrim_pkg::BIT_LINK_EN] &
                                   slope_wdog_trim[adtrim_pkg::BIT_LINK_ADJ];
    next_apply.wdog_trim_active = slope_wdog_trim[adtrim_pkg::BIT_WDOG_EN];
    next_apply.wdog_clock_trim_code = slope_wdog_trim[adtrim_pkg::BIT_WDOG_EN] ?
                                      slope_wdog_trim[2:0] : adtrim_pkg::CODE_NEUTRAL;
    if (bandgap_iref_trim[adtrim_pkg::BIT_BG_EN]) begin
      next_apply.bandgap_slope_up   = bandgap_iref_trim[adtrim_pkg::BIT_BG_UP];
      next_apply.bandgap_slope_down = bandgap_iref_trim[adtrim_pkg::BIT_BG_DOWN];
    end
    // 111 is neutral like 000, so it is passed through unchanged
    next_apply.current_ref_trim_code = bandgap_iref_trim[adtrim_pkg::BIT_IREF_EN] ?
        bandgap_iref_trim[2:0] : adtrim_pkg::CODE_NEUTRAL;
    if (sleep_ref_trim[adtrim_pkg::BIT_SLP_EN]) begin
      next_apply.sleep_ref_trim_code = sleep_ref_trim[2:0];
      next_apply.sleep_ref_locked    = sleep_ref_trim[adtrim_pkg::BIT_SLP_LOCK];
    end else begin
      next_apply.sleep_ref_trim_code = adtrim_pkg::SLEEP_CODE_DFLT;
    end
    next_apply.adc_offset_trim_code = adc_offset_trim[adtrim_pkg::BIT_ADC_EN] ?
        adc_offset_trim[adtrim_pkg::BIT_ADC_LO +: 3] : adtrim_pkg::CODE_NEUTRAL;
    // Percent offset of the 100 kHz watchdog base clock, 5 % steps
    case (next_apply.wdog_clock_trim_code)
      3'h0:    next_wdog_pct = 8'sd0;
      3'h1:    next_wdog_pct = 8'sd5;
      3'h2:    next_wdog_pct = 8'sd10;
      3'h3:    next_wdog_pct = 8'sd15;
      3'h4:    next_wdog_pct = -8'sd20;
      3'h5:    next_wdog_pct = -8'sd15;
      3'h6:    next_wdog_pct = -8'sd10;
      3'h7:    next_wdog_pct = -8'sd5;
      default: next_wdog_pct = 8'sd0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      slope_wdog_trim     <= adtrim_pkg::RESET_SLOPE_WDOG;
      bandgap_iref_trim   <= adtrim_pkg::RESET_BANDGAP;
      sleep_ref_trim      <= adtrim_pkg::RESET_SLEEP_REF;
      adc_offset_trim     <= adtrim_pkg::RESET_ADC_OFFSET;
      aw_addr             <= '0;
      aw_held             <= 1'b0;
      w_data              <= 32'h00000000;
      w_strb              <= 4'h0;
      w_held              <= 1'b0;
      b_resp              <= adtrim_pkg::RESP_OKAY;
      b_pend              <= 1'b0;
      r_data              <= 32'h00000000;
      r_resp              <= adtrim_pkg::RESP_OKAY;
      r_pend              <= 1'b0;
      TRIM_APPLY          <= '0;
      LINK_SLOPE_ADJUSTED <= 1'b0;
      WDOG_TRIM_PERCENT   <= 8'sd0;
      SLEEP_REF_LOCKED    <= 1'b0;
    end else if (CLK_EN) begin
      slope_wdog_trim     <= next_slope_wdog_trim;
      bandgap_iref_trim   <= next_bandgap_iref_trim;
      sleep_ref_trim      <= next_sleep_ref_trim;
      adc_offset_trim     <= next_adc_offset_trim;
      aw_addr             <= next_aw_addr;
      aw_held             <= next_aw_held;
      w_data              <= next_w_data;
      w_strb              <= next_w_strb;
      w_held              <= next_w_held;
      b_resp              <= next_b_resp;
      b_pend              <= next_b_pend;
      r_data              <= next_r_data;
      r_resp              <= next_r_resp;
      r_pend              <= next_r_pend;
      TRIM_APPLY          <= next_apply;
      LINK_SLOPE_ADJUSTED <= next_apply.link_slope_adjust;
      WDOG_TRIM_PERCENT   <= next_wdog_pct;
      SLEEP_REF_LOCKED    <= next_apply.sleep_ref_locked;
    end
  end

endmodule

// File: testbench/adtrim_bank_chk.sv
/*
  Port checker for the trim register bank, bound to its top module.
  Assumes one clock domain; CLK_EN low freezes every piece of state.
*/
`timescale 1ns/100ps
module adtrim_bank_chk (
  input wire logic                          CLK_SYS,
  input wire logic                          RESET_N,
  input wire logic                          CLK_EN,
  input wire logic                          S_AXI_AWVALID,
  input wire logic                          S_AXI_AWREADY,
  input wire logic                          S_AXI_WVALID,
  input wire logic                          S_AXI_WREADY,
  input wire logic [1:0]                    S_AXI_BRESP,
  input wire logic                          S_AXI_BVALID,
  input wire logic                          S_AXI_ARVALID,
  input wire logic                          S_AXI_ARREADY,
  input wire logic [31:0]                   S_AXI_RDATA,
  input wire logic                          S_AXI_RVALID,
  input wire adtrim_pkg::adtrim_apply_type  TRIM_APPLY,
  input wire logic                          LINK_SLOPE_ADJUSTED,
  input wire logic signed [7:0]             WDOG_TRIM_PERCENT,
  input wire logic                          SLEEP_REF_LOCKED
);
  localparam logic [7:0] PCT [8] = '{8'h00, 8'h05, 8'h0a, 8'h0f, 8'hec, 8'hf1, 8'hf6, 8'hfb};
  logic both_taken;
  assign both_taken = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CLK_EN;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  write_answer_a: assert property (both_taken ##1 CLK_EN |=> S_AXI_BVALID)
    else $error("write response missing");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && CLK_EN |=> S_AXI_RVALID)
    else $error("read response missing");
  busy_refuse_a: assert property ((S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    and (S_AXI_RVALID |-> !S_AXI_ARREADY)) else $error("request taken while busy");
  read_high_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  freeze_hold_a: assert property (!CLK_EN |=>
    $stable(TRIM_APPLY) && $stable(SLEEP_REF_LOCKED))
    else $error("trim outputs moved while frozen");
  link_out_a: assert property (LINK_SLOPE_ADJUSTED == TRIM_APPLY.link_slope_adjust)
    else $error("link slope output mismatch");
  wdog_off_a: assert property (!TRIM_APPLY.wdog_trim_active |->
    TRIM_APPLY.wdog_clock_trim_code == 3'h0 && WDOG_TRIM_PERCENT == 8'sh00)
    else $error("watchdog trim applied while disabled");
  wdog_pct_a: assert property (WDOG_TRIM_PERCENT == PCT[TRIM_APPLY.wdog_clock_trim_code])
    else $error("watchdog percent wrong");
  lock_hold_a: assert property (SLEEP_REF_LOCKED |=>
    SLEEP_REF_LOCKED && $stable(TRIM_APPLY.sleep_ref_trim_code)) else $error("lock broken");
  lock_out_a: assert property (SLEEP_REF_LOCKED == TRIM_APPLY.sleep_ref_locked)
    else $error("lock output mismatch");
  cover property (both_taken);
  cover property (SLEEP_REF_LOCKED);
  cover property (!CLK_EN);
  cover property (S_AXI_BVALID && S_AXI_BRESP == adtrim_pkg::RESP_SLVERR);
endmodule
bind adtrim_bank adtrim_bank_chk adtrim_bank_chk_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .CLK_EN(CLK_EN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .TRIM_APPLY(TRIM_APPLY),
  .LINK_SLOPE_ADJUSTED(LINK_SLOPE_ADJUSTED), .WDOG_TRIM_PERCENT(WDOG_TRIM_PERCENT),
  .SLEEP_REF_LOCKED(SLEEP_REF_LOCKED));

// File: testbench/adtrim_info_row.sv
/*
  Model of the flash information row that holds the factory trim bytes.
  Assumes the reader opens the row before fetching; a closed row reads zero.
*/
`timescale 1ns/100ps
module adtrim_info_row #(
  parameter logic [7:0] ROW_4C = 8'hfe,
  parameter logic [7:0] ROW_4D = 8'hab,
  parameter logic [7:0] ROW_4E = 8'h1b,
  parameter logic [7:0] ROW_4F = 8'hd5
) (
  input wire logic        row_en,
  input wire logic [7:0]  addr,
  output logic [7:0]      data
);
  always_comb begin
    data = 8'h00;
    if (row_en) begin
      case (addr)
        8'h4c: data = ROW_4C;
        8'h4d: data = ROW_4D;
        8'h4e: data = ROW_4E;
        8'h4f: data = ROW_4F;
        default: data = 8'h00;
      endcase
    end
  end
endmodule

// File: testbench/adtrim_bank_bench.sv
/*
  Self-checking bench for the trim register bank over AXI4-Lite.
  Assumes the package, the info row model and the checker are compiled first.
*/
`timescale 1ns/100ps
module adtrim_bank_bench;
  logic                          clk, rst_n, clk_en, low_power, row_en;
  logic                          aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic                          aw_ready, w_ready, b_valid, ar_ready, r_valid, link_adj, locked;
  logic [11:0]                   aw_addr, ar_addr;
  logic [31:0]                   w_data, r_data;
  logic [3:0]                    w_strb;
  logic [1:0]                    b_resp, r_resp;
  logic [7:0]                    row_addr, row_data;
  logic signed [7:0]             wdog_pct;
  adtrim_pkg::adtrim_apply_type  apply;
  logic [7:0]                    sh [4];
  logic [7:0]                    pct_tab [8] = '{8'h00, 8'h05, 8'h0a, 8'h0f,
                                                 8'hec, 8'hf1, 8'hf6, 8'hfb};
  int                            bad_count = 0, n_compared = 0, cycles = 0;

  adtrim_bank adtrim_bank_inst (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(clk_en),
    .LOW_POWER(low_power), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
    .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .TRIM_APPLY(apply),
    .LINK_SLOPE_ADJUSTED(link_adj), .WDOG_TRIM_PERCENT(wdog_pct), .SLEEP_REF_LOCKED(locked));
  adtrim_info_row adtrim_info_row_inst (.row_en(row_en), .addr(row_addr), .data(row_data));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
    end
  endtask

  function automatic logic [11:0] ra(input int i);
    return {2'b00, adtrim_pkg::REG_IDX_SLOPE_WDOG + i[7:0], 2'b00};
  endfunction

  // Both channels offered together; ready is checked at each edge
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    aw_addr <= a;
    w_data <= {24'h000000, d};
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
    end while (aw_valid || w_valid);
    do @(posedge clk); while (!b_valid);
    r = b_resp;
    b_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(posedge clk); while (!ar_ready);
    ar_valid <= 1'b0;
    do @(posedge clk); while (!r_valid);
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    logic [1:0] r;
    axi_write(ra(i), d, 4'h1, r);
    chk({30'h0, r}, {30'h0, adtrim_pkg::RESP_OKAY});
    if (i != 2) sh[i] = d;
    else if (!sh[2][3]) sh[2] = d & adtrim_pkg::SLEEP_WRITE_MASK;
  endtask

  // Reads every register back and compares the effective trim outputs
  task automatic check_all;
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] p;
    adtrim_pkg::adtrim_apply_type e;
    for (int i = 0; i < 4; i++) begin
      axi_read(ra(i), v, r);
      chk(v, {24'h000000, sh[i]});
      chk({30'h0, r}, {30'h0, adtrim_pkg::RESP_OKAY});
    end
    e.link_slope_adjust = sh[0][7] & sh[0][6];
    e.wdog_trim_active = sh[0][5];
    e.wdog_clock_trim_code = sh[0][5] ? sh[0][2:0] : 3'h0;
    e.bandgap_slope_up = sh[1][7] & sh[1][5];
    e.bandgap_slope_down = sh[1][7] & sh[1][4];
    e.current_ref_trim_code = sh[1][3] ? sh[1][2:0] : 3'h0;
    e.sleep_ref_trim_code = sh[2][4] ? sh[2][2:0] : 3'h0;
    e.sleep_ref_locked = sh[2][4] & sh[2][3];
    e.adc_offset_trim_code = sh[3][7] ? sh[3][6:4] : 3'h0;
    p = sh[0][5] ? pct_tab[sh[0][2:0]] : 8'h00;
    chk({5'h00, wdog_pct, link_adj, locked, apply},
        {5'h00, p, e.link_slope_adjust, e.sleep_ref_locked, e});
  endtask

  task automatic t_sleep_search;
    wr(2, 8'he5);
    check_all;
    for (int c = 0; c < 8; c++) begin
      wr(2, 8'h10 | c[7:0]);
      check_all;
    end
    $display("sleep trim search done");
  endtask

  // Startup copy from the info row; the third byte locks the sleep trim
  task automatic t_startup;
    row_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      row_addr <= 8'h4c + i[7:0];
      @(posedge clk);
      wr(i, row_data);
    end
    check_all;
    wr(2, 8'h06);
    wr(2, 8'h14);
    check_all;
    $display("startup copy and lock done");
  endtask

  task automatic t_gates;
    for (int c = 0; c < 8; c++) begin
      wr(0, 8'h60 | c[7:0]);
      check_all;
    end
    wr(0, 8'h9f);
    wr(1, 8'h3f);
    wr(3, 8'h7f);
    check_all;
    wr(0, 8'hc0);
    wr(1, 8'h96);
    wr(3, 8'hd5);
    check_all;
    $display("enable gating done");
  endtask

  task automatic t_bus_edges;
    logic [31:0] v;
    logic [1:0] r;
    axi_write(ra(4), 8'hff, 4'h1, r);
    chk({30'h0, r}, {30'h0, adtrim_pkg::RESP_SLVERR});
    axi_read(ra(4), v, r);
    chk({30'h0, r}, {30'h0, adtrim_pkg::RESP_SLVERR});
    chk(v, 32'h00000000);
    axi_write(ra(0), 8'h00, 4'h0, r);
    chk({30'h0, r}, {30'h0, adtrim_pkg::RESP_OKAY});
    check_all;
    $display("unmapped and strobe done");
  endtask

  task automatic t_retain;
    low_power <= 1'b1;
    repeat (4) @(posedge clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge clk);
    clk_en <= 1'b1;
    check_all;
    low_power <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sh = '{default: 8'h00};
    check_all;
    wr(2, 8'h1a);
    check_all;
    $display("retention and reset done");
  endtask

  initial begin
    {clk, rst_n, low_power, row_en, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    clk_en = 1'b1;
    {aw_addr, ar_addr, w_data, w_strb, row_addr} = '0;
    sh = '{default: 8'h00};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_all;
    $display("reset values done");
    t_sleep_search;
    t_startup;
    t_gates;
    t_bus_edges;
    t_retain;
    wrap_up;
  end
endmodule
